// *** spipt_top.sv ***
`timescale 1ns/100ps
// How it works
// - Slave, select held between words: resend last received word.
// - Slave, select released half a clock: send the data word.
// - Master with select output: release select between every transfer.
// - Lead, trail and idle half cycles kept as master, needed as slave.
// - Phase one: first clock edge starts the n-cycle transfer.
// - First edge follows a half-cycle delay and presents first bit.
// - Second edge half a cycle later; both sides sample on it.
// - Third edge shifts sampled bit in per bit order, then drives next.
// - Sample on even edges, shift on odd, until width's edge count.
// - Width select one gives sixteen-bit transfers.
module spipt_top
	import spipt_pkg::*;
#(
	parameter int HALF_CYC = HALF_SCK_CYC
)(
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              master_en,
	input  wire logic              ss_out_en,
	input  wire logic              clock_phase_sel,
	input  wire logic              lsb_first_en,
	input  wire logic              transfer_width_sel,
	input  wire logic              start,
	input  wire logic [WORD_W-1:0] tx_data,
	output logic                   busy,
	output logic                   rx_valid,
	output logic [WORD_W-1:0]      rx_data,
	output logic                   sck_o,
	output logic                   sck_oe,
	output logic                   ss_n_o,
	output logic                   ss_n_oe,
	output logic                   mosi_o,
	output logic                   mosi_oe,
	input  wire logic              miso_i,
	input  wire logic              sclk_i,
	input  wire logic              ss_n_i,
	input  wire logic              mosi_i,
	output logic                   miso_o,
	output logic                   miso_oe
);
	localparam logic [7:0] DIV_LAST = 8'(HALF_CYC - 1);

	spipt_state_t      state_reg;
	spipt_state_t      state_next;
	logic [7:0]        div_reg;
	logic [CNT_W-1:0]  edge_reg;
	logic [WORD_W-1:0] sr_reg;
	logic [WORD_W-1:0] tx_word_reg;
	logic              samp_reg;
	logic              sck_reg;
	logic              ss_n_reg;
	logic              mosi_reg;
	logic              miso_s1_reg;
	logic              miso_s2_reg;
	logic [WORD_W-1:0] slv_rx_word;
	logic              slv_tog;
	logic              tog_s1_reg;
	logic              tog_s2_reg;
	logic              tog_prev_reg;
	logic              tick;
	logic              take;
	logic              odd_now;
	logic              last_even;
	logic              slv_done;
	logic [WORD_W-1:0] m_shifted;
	logic [CNT_W-1:0]  edges_total;

	assign tick        = (state_reg != SPIPT_IDLE) && (div_reg == DIV_LAST);
	// Phase zero timing is not built; such a start is ignored
	assign take        = start && master_en && clock_phase_sel &&
	                     (state_reg == SPIPT_IDLE);
	assign edges_total = sp_bits(transfer_width_sel) << 1;
	assign odd_now     = edge_reg[0];
	assign last_even   = (edge_reg + 6'h01 == edges_total);
	assign m_shifted   = sp_shift_in(sr_reg, samp_reg, lsb_first_en,
	                                 transfer_width_sel);
	assign slv_done    = tog_s2_reg ^ tog_prev_reg;
	assign busy        = (state_reg != SPIPT_IDLE);
	assign sck_o       = sck_reg;
	assign ss_n_o      = ss_n_reg;
	assign mosi_o      = mosi_reg;
	assign sck_oe      = master_en;
	assign mosi_oe     = master_en;
	assign ss_n_oe     = master_en && ss_out_en;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
		SPIPT_IDLE: begin
			if (take) begin
				state_next = SPIPT_LEAD;
			end
		end
		SPIPT_LEAD: begin
			if (tick) begin
				state_next = SPIPT_XFER;
			end
		end
		SPIPT_XFER: begin
			if (tick && odd_now && last_even) begin
				state_next = SPIPT_TRAIL;
			end
		end
		SPIPT_TRAIL: begin
			if (tick) begin
				state_next = SPIPT_GAP;
			end
		end
		SPIPT_GAP: begin
			if (tick) begin
				state_next = SPIPT_IDLE;
			end
		end
		default: state_next = SPIPT_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= SPIPT_IDLE;
			div_reg   <= '0;
		end else begin
			state_reg <= state_next;
			div_reg   <= (tick || !busy) ? '0 : div_reg + 8'h01;
		end
	end

	// Master shifter and pins
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			edge_reg <= '0;
			sr_reg   <= WORD_ZERO;
			samp_reg <= 1'b0;
			sck_reg  <= 1'b0;
			ss_n_reg <= 1'b1;
			mosi_reg <= 1'b0;
		end else if (take) begin
			sr_reg   <= tx_data;
			edge_reg <= '0;
			ss_n_reg <= !ss_out_en;
		end else if (tick) begin
			case (state_reg)
			SPIPT_LEAD: begin
				sck_reg  <= 1'b1;
				edge_reg <= 6'h01;
				mosi_reg <= sp_out_bit(sr_reg, lsb_first_en,
				                       transfer_width_sel);
			end
			SPIPT_XFER: begin
				edge_reg <= edge_reg + 6'h01;
				if (odd_now) begin
					sck_reg  <= 1'b0;
					samp_reg <= miso_s2_reg;
				end else begin
					sck_reg  <= 1'b1;
					sr_reg   <= m_shifted;
					mosi_reg <= sp_out_bit(m_shifted, lsb_first_en,
					                       transfer_width_sel);
				end
			end
			SPIPT_TRAIL: begin
				sr_reg   <= m_shifted;
				ss_n_reg <= 1'b1;
			end
			default: begin
				ss_n_reg <= 1'b1;
			end
			endcase
		end
	end

	// Pin and toggle synchronisers, then result hand-off
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			miso_s1_reg  <= 1'b0;
			miso_s2_reg  <= 1'b0;
			tog_s1_reg   <= 1'b0;
			tog_s2_reg   <= 1'b0;
			tog_prev_reg <= 1'b0;
			rx_valid     <= 1'b0;
			rx_data      <= WORD_ZERO;
			tx_word_reg  <= WORD_ZERO;
		end else begin
			miso_s1_reg  <= miso_i;
			miso_s2_reg  <= miso_s1_reg;
			tog_s1_reg   <= slv_tog;
			tog_s2_reg   <= tog_s1_reg;
			tog_prev_reg <= tog_s2_reg;
			rx_valid     <= 1'b0;
			if (start && !master_en) begin
				tx_word_reg <= tx_data;
			end
			if (tick && state_reg == SPIPT_TRAIL) begin
				rx_valid <= 1'b1;
				rx_data  <= sp_mask(m_shifted, transfer_width_sel);
			end else if (slv_done && !master_en) begin
				rx_valid <= 1'b1;
				rx_data  <= slv_rx_word;
			end
		end
	end

	spipt_slave_link u_slave (
		.rst                (rst),
		.sclk_i             (sclk_i),
		.ss_n_i             (ss_n_i),
		.mosi_i             (mosi_i),
		.lsb_first_en       (lsb_first_en),
		.transfer_width_sel (transfer_width_sel),
		.tx_word            (tx_word_reg),
		.miso_o             (miso_o),
		.miso_oe            (miso_oe),
		.rx_word            (slv_rx_word),
		.rx_toggle          (slv_tog)
	);

	// Helper: rising sck edges per frame
	logic [CNT_W-1:0] rises_reg;
	always_ff @(posedge sys_clk) begin
		if (rst || take) begin
			rises_reg <= '0;
		end else if (sck_reg == 1'b0 && tick &&
		             (state_reg == SPIPT_LEAD ||
		              (state_reg == SPIPT_XFER && !odd_now))) begin
			rises_reg <= rises_reg + 6'h01;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	AST_GAP_SS_HIGH: assert property (
		(state_reg == SPIPT_GAP) |-> ss_n_reg)
		else $error("select low during gap");
	AST_IDLE_TIME: assert property (
		(ss_out_en && $rose(ss_n_reg)) |-> ss_n_reg [*4])
		else $error("select idle shorter than half clock");
	AST_LEAD_DELAY: assert property (
		$fell(ss_n_reg) |-> !sck_reg [*4] ##1 sck_reg)
		else $error("first edge not after half-cycle lead");
	AST_SAMPLE_EVEN: assert property (
		(busy && $fell(sck_reg)) |-> !edge_reg[0])
		else $error("sample not on even edge");
	AST_SHIFT_ODD: assert property (
		($past(state_reg) == SPIPT_XFER && $rose(sck_reg)) |->
		sr_reg == sp_shift_in($past(sr_reg), $past(samp_reg),
		                      lsb_first_en, transfer_width_sel))
		else $error("odd edge did not shift in sampled bit");
	AST_EDGE_TOTAL: assert property (
		(tick && state_reg == SPIPT_TRAIL) |-> rises_reg ==
		sp_bits(transfer_width_sel) && edge_reg == edges_total)
		else $error("wrong edge count for width");
	AST_TRAIL_TIME: assert property (
		(state_reg == SPIPT_XFER && state_next == SPIPT_TRAIL) |=>
		(!sck_reg && busy) [*4])
		else $error("trail time short");
	AST_RESULT: assert property (
		(tick && state_reg == SPIPT_TRAIL) |=> rx_valid ##1 !rx_valid)
		else $error("result pulse missing");

	COV_W8: cover property (take && !transfer_width_sel ##[1:200] rx_valid);
	COV_W16: cover property (take && transfer_width_sel ##[1:300] rx_valid);
	COV_LSB: cover property (take && lsb_first_en);
	COV_B2B: cover property (rx_valid ##[1:20] take);

endmodule

// *** spipt_pkg.sv ***
package spipt_pkg;

	localparam int SYS_PERIOD_NS = 25;
	localparam int HALF_SCK_NS   = 100;
	// Least time, so round up to whole cycles
	localparam int HALF_SCK_CYC  = (HALF_SCK_NS + SYS_PERIOD_NS - 1)
	                               / SYS_PERIOD_NS;
	localparam int WORD_W        = 16;
	localparam int CNT_W         = 6;
	localparam logic [CNT_W-1:0] BITS_NARROW = 6'h08;
	localparam logic [CNT_W-1:0] BITS_WIDE   = 6'h10;
	localparam logic [WORD_W-1:0] WORD_ZERO  = 16'h0000;

	typedef enum logic [2:0] {
		SPIPT_IDLE  = 3'b000,
		SPIPT_LEAD  = 3'b001,
		SPIPT_XFER  = 3'b010,
		SPIPT_TRAIL = 3'b011,
		SPIPT_GAP   = 3'b100
	} spipt_state_t;

	function automatic logic [CNT_W-1:0] sp_bits(input logic wide);
		return wide ? BITS_WIDE : BITS_NARROW;
	endfunction

	// Bit that leaves the shifter next
	function automatic logic sp_out_bit(input logic [WORD_W-1:0] sr,
		input logic lsb, input logic wide);
		return lsb ? sr[0] : (wide ? sr[15] : sr[7]);
	endfunction

	// Sampled bit enters at the far end from the one that leaves
	function automatic logic [WORD_W-1:0] sp_shift_in(
		input logic [WORD_W-1:0] sr, input logic b,
		input logic lsb, input logic wide);
		logic [WORD_W-1:0] r;
		r = lsb ? {b, sr[15:1]} : {sr[14:0], b};
		if (lsb && !wide) begin
			r = {8'h00, b, sr[7:1]};
		end
		return r;
	endfunction

	function automatic logic [WORD_W-1:0] sp_mask(
		input logic [WORD_W-1:0] w, input logic wide);
		return wide ? w : {8'h00, w[7:0]};
	endfunction

endpackage

// *** spipt_slave_link.sv ***
`timescale 1ns/100ps
module spipt_slave_link
	import spipt_pkg::*;
(
	input  wire logic              rst,
	input  wire logic              sclk_i,
	input  wire logic              ss_n_i,
	input  wire logic              mosi_i,
	input  wire logic              lsb_first_en,
	input  wire logic              transfer_width_sel,
	input  wire logic [WORD_W-1:0] tx_word,
	output logic                   miso_o,
	output logic                   miso_oe,
	output logic [WORD_W-1:0]      rx_word,
	output logic                   rx_toggle
);
	// Config and tx_word are held static by the sys side while selected
	logic [WORD_W-1:0] sr_reg;
	logic [WORD_W-1:0] last_rx_reg;
	logic [CNT_W-1:0]  cnt_reg;
	logic              samp_reg;
	logic              released_reg;
	logic [WORD_W-1:0] load_word;
	logic [WORD_W-1:0] shifted;
	logic [WORD_W-1:0] done_word;
	logic              load_now;
	logic              last_bit;

	assign load_now  = (cnt_reg == '0);
	assign load_word = released_reg ? tx_word : last_rx_reg;
	assign shifted   = sp_shift_in(sr_reg, samp_reg, lsb_first_en,
	                               transfer_width_sel);
	assign done_word = sp_mask(sp_shift_in(sr_reg, mosi_i, lsb_first_en,
	                           transfer_width_sel), transfer_width_sel);
	assign last_bit  = (cnt_reg == sp_bits(transfer_width_sel) - 6'h01);
	assign miso_oe   = !ss_n_i;

	// Select high sets the flag; no sclk edges exist outside frames
	// Reset too: select may sit high from power-up with no edge at all
	always_ff @(posedge sclk_i or posedge ss_n_i or posedge rst) begin
		if (ss_n_i || rst) begin
			released_reg <= 1'b1;
		end else if (load_now) begin
			released_reg <= 1'b0;
		end
	end

	// Odd edges: load or shift, then present the next bit
	always_ff @(posedge sclk_i) begin
		if (load_now) begin
			sr_reg <= load_word;
			miso_o <= sp_out_bit(load_word, lsb_first_en,
			                     transfer_width_sel);
		end else begin
			sr_reg <= shifted;
			miso_o <= sp_out_bit(shifted, lsb_first_en,
			                     transfer_width_sel);
		end
	end

	always_ff @(negedge sclk_i or posedge ss_n_i or posedge rst) begin
		if (ss_n_i || rst) begin
			cnt_reg <= '0;
		end else if (last_bit) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 6'h01;
		end
	end

	// Even edges: sample; last one completes the word
	always_ff @(negedge sclk_i or posedge rst) begin
		if (rst) begin
			samp_reg    <= 1'b0;
			last_rx_reg <= WORD_ZERO;
			rx_word     <= WORD_ZERO;
			rx_toggle   <= 1'b0;
		end else begin
			samp_reg <= mosi_i;
			if (last_bit && !ss_n_i) begin
				last_rx_reg <= done_word;
				rx_word     <= done_word;
				rx_toggle   <= !rx_toggle;
			end
		end
	end

	property p_fresh;
		@(posedge sclk_i) disable iff (ss_n_i)
		(load_now && released_reg) |=> (sr_reg == $past(tx_word));
	endproperty
	AST_SLV_FRESH: assert property (p_fresh)
		else $error("slave did not load data word after release");

	AST_SLV_LAST: assert property (
		@(posedge sclk_i) disable iff (ss_n_i)
		(load_now && !released_reg) |=> (sr_reg == $past(last_rx_reg)))
		else $error("slave did not resend last received word");

	AST_SLV_CNT: assert property (
		@(negedge sclk_i) disable iff (ss_n_i || rst)
		cnt_reg < sp_bits(transfer_width_sel))
		else $error("slave edge count past word width");

	COV_SLV_BACK: cover property (
		@(posedge sclk_i) disable iff (ss_n_i)
		load_now && !released_reg);

endmodule

// *** spipt_partner.sv ***
`timescale 1ns/100ps
module spipt_partner
	import spipt_pkg::*;
#(
	parameter int HALF_NS = 100
)(
	input  wire logic sck_o,
	input  wire logic ss_n_o,
	input  wire logic mosi_o,
	output logic      miso_i,
	output logic      sclk_i,
	output logic      ss_n_i,
	output logic      mosi_i,
	input  wire logic miso_o,
	input  wire logic lsb_first_en,
	input  wire logic transfer_width_sel
);
	logic [WORD_W-1:0] m_word;
	logic [WORD_W-1:0] m_cap;
	logic [WORD_W-1:0] m_got;
	int                m_edges;
	int                m_idx;
	int                viol;
	int                nb;
	realtime           t_fall;
	realtime           t_rise;
	realtime           t_sck;

	assign nb = transfer_width_sel ? 16 : 8;

	// Sampled bit enters at the end away from the leaving one
	function automatic logic [WORD_W-1:0] fold(logic [WORD_W-1:0] s,
		logic b);
		if (!lsb_first_en) begin
			return {s[14:0], b};
		end
		return transfer_width_sel ? {b, s[15:1]} : {8'h00, b, s[7:1]};
	endfunction

	initial begin
		{miso_i, sclk_i, mosi_i} = 3'b000;
		ss_n_i = 1'b1;
		m_word = 16'h0000;
		m_got = 16'h0000;
		{viol, m_edges, m_idx} = {32'h0, 32'h0, 32'h0};
		t_rise = -1000.0;
		t_sck = 0.0;
	end

	// Idle gap is the master's duty
	always @(negedge ss_n_o) begin
		if ($realtime - t_rise < HALF_NS) viol++;
		t_fall = $realtime;
		{m_idx, m_edges} = {32'h0, 32'h0};
		m_cap = 16'h0000;
	end

	// Trail time; line then shows the inverse, not a held value
	always @(posedge ss_n_o) begin
		if (m_edges > 0 && $realtime - t_sck < HALF_NS) viol++;
		t_rise = $realtime;
		m_got = m_cap;
		miso_i = ~miso_i;
	end

	// Odd edges present the next bit, first one after half a cycle
	always @(posedge sck_o) if (ss_n_o === 1'b0) begin
		if (m_edges == 0 && $realtime - t_fall != HALF_NS) viol++;
		miso_i = m_word[lsb_first_en ? m_idx : nb - 1 - m_idx];
		m_idx++;
		m_edges++;
	end

	// Even edges sample
	always @(negedge sck_o) if (ss_n_o === 1'b0) begin
		t_sck = $realtime;
		m_cap = fold(m_cap, mosi_o);
	end

	// Link clock of 48 ns runs only inside frames
	task automatic sxfer(input logic [WORD_W-1:0] w, input logic hold,
		output logic [WORD_W-1:0] got);
		got = 16'h0000;
		ss_n_i = 1'b0;
		#24;
		for (int i = 0; i < nb; i++) begin
			sclk_i = 1'b1;
			mosi_i = w[lsb_first_en ? i : nb - 1 - i];
			#24;
			sclk_i = 1'b0;
			got = fold(got, miso_o);
			#24;
		end
		mosi_i = ~mosi_i;
		#200;
		if (!hold) ss_n_i = 1'b1;
		#200;
	endtask
endmodule

// *** spipt_top_tb_top.sv ***
`timescale 1ns/100ps
module spipt_top_tb_top;
	import spipt_pkg::*;
	logic              sys_clk = 1'b0;
	logic              rst = 1'b0;
	logic              master_en = 1'b1;
	logic              ss_out_en = 1'b1;
	logic              clock_phase_sel = 1'b1;
	logic              lsb_first_en = 1'b0;
	logic              transfer_width_sel = 1'b0;
	logic              start = 1'b0;
	logic [WORD_W-1:0] tx_data = 16'h0000;
	logic              busy, rx_valid, sck_o, ss_n_o, mosi_o, miso_i;
	logic              sclk_i, ss_n_i, mosi_i, miso_o;
	logic              sck_oe, ss_n_oe, mosi_oe, miso_oe;
	logic [WORD_W-1:0] rx_data;
	logic [WORD_W-1:0] exp_q[$];
	integer            seed = 32'h1c1a8df6;
	int                err_total = 0;
	int                n_tests = 0;

	always #12.5 sys_clk = ~sys_clk;

	spipt_top u_spipt_top (.sys_clk, .rst, .master_en, .ss_out_en,
		.clock_phase_sel, .lsb_first_en, .transfer_width_sel, .start,
		.tx_data, .busy, .rx_valid, .rx_data, .sck_o, .sck_oe,
		.ss_n_o, .ss_n_oe, .mosi_o, .mosi_oe, .miso_i, .sclk_i,
		.ss_n_i, .mosi_i, .miso_o, .miso_oe);

	spipt_partner u_spipt_partner (.sck_o, .ss_n_o, .mosi_o, .miso_i,
		.sclk_i, .ss_n_i, .mosi_i, .miso_o, .lsb_first_en,
		.transfer_width_sel);

	task automatic check(input logic [WORD_W-1:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	function automatic logic [WORD_W-1:0] msk(logic [WORD_W-1:0] w);
		return transfer_width_sel ? w : {8'h00, w[7:0]};
	endfunction

	task automatic pulse_start;
		start = 1'b1;
		@(negedge sys_clk);
		start = 1'b0;
	endtask

	task automatic mxfer;
		tx_data = 16'($random(seed));
		u_spipt_partner.m_word = 16'($random(seed));
		exp_q.push_back(msk(u_spipt_partner.m_word));
		pulse_start;
		check({14'h0000, sck_oe, mosi_oe}, 16'h0003);
		check({15'h0000, ss_n_oe}, {15'h0000, ss_out_en});
		for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge sys_clk);
		if (busy !== 1'b0) err_total++;
		check(u_spipt_partner.m_got, msk(tx_data));
		check(16'(u_spipt_partner.m_edges),
			transfer_width_sel ? 16'h0010 : 16'h0008);
	endtask

	// Second word with select held low must echo the first
	task automatic sside;
		logic [WORD_W-1:0] w1, w2, got;
		master_en = 1'b0;
		tx_data = 16'($random(seed));
		pulse_start;
		w1 = 16'($random(seed));
		w2 = 16'($random(seed));
		exp_q.push_back(msk(w1));
		u_spipt_partner.sxfer(w1, 1'b1, got);
		check(got, msk(tx_data));
		check({15'h0000, miso_oe}, 16'h0001);
		check({14'h0000, sck_oe, mosi_oe}, 16'h0000);
		exp_q.push_back(msk(w2));
		u_spipt_partner.sxfer(w2, 1'b0, got);
		check(got, msk(w1));
		check({15'h0000, miso_oe}, 16'h0000);
		@(negedge sys_clk);
		master_en = 1'b1;
	endtask

	// Results are matched in order of arrival against the noted words
	always @(negedge sys_clk) begin
		if (rx_valid === 1'b1) begin
			check(rx_data, exp_q.size() ? exp_q.pop_front()
				: ~rx_data);
		end
	end

	initial begin
		// A real rising edge, so the link-side async resets act
		#1 rst = 1'b1;
		repeat (4) @(negedge sys_clk);
		rst = 1'b0;
		for (int m = 0; m < 4; m++) begin
			{transfer_width_sel, lsb_first_en} = m[1:0];
			@(negedge sys_clk);
			mxfer;
			mxfer;
			sside;
		end
		// Select output off: pin stays high, frame still runs
		ss_out_en = 1'b0;
		exp_q.push_back(u_spipt_partner.miso_i ? msk(16'hffff) : WORD_ZERO);
		pulse_start;
		check({15'h0000, ss_n_oe}, 16'h0000);
		for (int i = 0; i < 200 && busy !== 1'b0; i++) begin
			@(negedge sys_clk);
			check({15'h0000, ss_n_o}, 16'h0001);
		end
		check({15'h0000, busy}, 16'h0000);
		ss_out_en = 1'b1;
		@(negedge sys_clk);
		clock_phase_sel = 1'b0;
		pulse_start;
		@(negedge sys_clk);
		check({15'h0000, busy}, 16'h0000);
		clock_phase_sel = 1'b1;
		repeat (10) @(negedge sys_clk);
		check(16'(exp_q.size()), 16'h0000);
		check(16'(u_spipt_partner.viol), 16'h0000);
		complete_run;
	end

	// Whole run needs about 33 us; six times that means a hang
	initial begin
		#200000;
		err_total++;
		complete_run;
	end
endmodule
